/* rtl/isvc_handshake.v */
// adapter-side interrupt service handshake towards an attached device
// Overview of operation
// - address is driven onto the address lines before any tag rises.
// - service-active tag rises at least 200 ns after address is valid.
// - after select response, strobe is pulsed while service-active stays asserted.
// - service-active tag falls only after the strobe pulse ends, or with no strobe when the select response times out.
// - address is removed as the last step of the exchange.
// - every interface line is asserted when low.
// - program-controlled transfers only; no memory access path exists.
// - zero-delay device exchange adds at most 2.5 us.
// - separate eight-bit in and out buses, each with one parity line.
// - sixteen separate interrupt request inputs, numbered 0 to 15.
`timescale 1ns/1ns
`default_nettype none
`include "isvc_defines.vh"
module isvc_handshake #(
   parameter ADDR_W     = 8,
   parameter SKEW_CYC   = `ADDR_SKEW_CYC,
   parameter STROBE_CYC = `STROBE_WIDTH_CYC,
   parameter TIMEOUT    = `RESP_TIMEOUT_CYC
) (
   input  wire              CLK,
   input  wire              SYS_RST,
   input  wire              SVC_START,
   input  wire [ADDR_W-1:0] SVC_ADDR,
   input  wire [7:0]        DATA_OUT_VAL,
   output reg               SVC_BUSY,
   output reg               SVC_DONE,
   output reg               SVC_TIMEOUT,
   output reg  [7:0]        SVC_DATA,
   output reg  [3:0]        SVC_COND,
   output reg               SVC_PAR_ERR,
   output reg  [15:0]       IRQ_PENDING,
   output reg  [ADDR_W-1:0] ADDR_N,
   output reg               ADDR_OE,
   output reg               SVC_ACTIVE_N,
   output reg               STROBE_N,
   output reg  [7:0]        DBUS_OUT_N,
   output reg               DBUS_OUT_PAR_N,
   input  wire              SEL_RESP_N,
   input  wire [3:0]        COND_IN_N,
   input  wire [7:0]        DBUS_IN_N,
   input  wire              DBUS_IN_PAR_N,
   input  wire [15:0]       IRQ_N
);
   localparam S_IDLE = 6'b000001;
   localparam S_SKEW = 6'b000010;
   localparam S_WAIT = 6'b000100;
   localparam S_STRB = 6'b001000;
   localparam S_DROP = 6'b010000;
   localparam S_ADDR = 6'b100000;

   // odd parity over a byte: parity line asserted makes total odd
   function odd_par;
      input [7:0] b;
      begin
         odd_par = ~(^b);
      end
   endfunction

   // counter has reached the last cycle of a phase lasting limit cycles
   function count_done;
      input [7:0] count;
      input [7:0] limit;
      begin
         count_done = (count >= limit - 8'h01);
      end
   endfunction

   // sequencer and registered next values
   reg  [5:0]        state;
   reg  [7:0]        cnt;
   reg  [5:0]        next_state;
   reg  [7:0]        next_cnt;
   reg               next_busy;
   reg               next_done;
   reg               next_timeout;
   reg  [7:0]        next_data;
   reg  [3:0]        next_cond;
   reg               next_par_err;
   reg  [ADDR_W-1:0] next_addr_n;
   reg               next_addr_oe;
   reg               next_active_n;
   reg               next_strobe_n;
   reg  [7:0]        next_dbus_n;
   reg               next_dbus_par_n;

   // synchronised inputs and decoded phase ends
   wire [12:0]       in_raw;
   wire              sel_s;
   wire [15:0]       irq_s;
   wire [12:0]       in_s;
   wire              skew_end;
   wire              strobe_end;
   wire              resp_late;
   genvar            k;

   assign in_raw     = ~{DBUS_IN_PAR_N, COND_IN_N, DBUS_IN_N};
   assign skew_end   = count_done(cnt, SKEW_CYC[7:0]);
   assign strobe_end = count_done(cnt, STROBE_CYC[7:0]);
   assign resp_late  = (cnt >= TIMEOUT[7:0]);

   // active-low tags inverted before synchronising
   tag_sync #(.WIDTH(1)) u_sel_sync (
      .clk  (CLK),
      .rst  (SYS_RST),
      .din  (~SEL_RESP_N),
      .dout (sel_s)
   );
   // one synchroniser per request line
   generate
      for (k = 0; k < 16; k = k + 1) begin : g_irq_sync
         tag_sync #(.WIDTH(1)) u_irq_sync (
            .clk  (CLK),
            .rst  (SYS_RST),
            .din  (~IRQ_N[k]),
            .dout (irq_s[k])
         );
      end
   endgenerate
   // parity, condition code and data bus in, one synchroniser per bit, 13 in all
   generate
      for (k = 0; k < 13; k = k + 1) begin : g_in_sync
         tag_sync #(.WIDTH(1)) u_in_sync (
            .clk  (CLK),
            .rst  (SYS_RST),
            .din  (in_raw[k]),
            .dout (in_s[k])
         );
      end
   endgenerate

   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         IRQ_PENDING <= 16'h0000;
      end else begin
         IRQ_PENDING <= irq_s;
      end
   end

   // next-state decode; only programmed exchanges exist, no memory path
   always @* begin
      // hold everything except done and timeout, which default low, unless the phase below changes it
      next_state      = state;
      next_cnt        = cnt;
      next_busy       = SVC_BUSY;
      next_done       = 1'b0;
      next_timeout    = 1'b0;
      next_data       = SVC_DATA;
      next_cond       = SVC_COND;
      next_par_err    = SVC_PAR_ERR;
      next_addr_n     = ADDR_N;
      next_addr_oe    = ADDR_OE;
      next_active_n   = SVC_ACTIVE_N;
      next_strobe_n   = STROBE_N;
      next_dbus_n     = DBUS_OUT_N;
      next_dbus_par_n = DBUS_OUT_PAR_N;
      case (state)
         S_IDLE: begin
            if (SVC_START) begin
               next_addr_n     = ~SVC_ADDR;
               next_addr_oe    = 1'b1;
               next_dbus_n     = ~DATA_OUT_VAL;
               next_dbus_par_n = ~odd_par(DATA_OUT_VAL);
               next_busy       = 1'b1;
               next_cnt        = 8'h00;
               next_state      = S_SKEW;
            end
         end
         S_SKEW: begin
            if (skew_end) begin
               next_active_n = 1'b0;
               next_cnt      = 8'h00;
               next_state    = S_WAIT;
            end else begin
               next_cnt = cnt + 8'h01;
            end
         end
         S_WAIT: begin
            if (sel_s) begin
               // capture code and data on the same edge that asserts strobe
               next_data     = in_s[7:0];
               next_cond     = in_s[11:8];
               next_par_err  = (in_s[12] != odd_par(in_s[7:0]));
               next_strobe_n = 1'b0;
               next_cnt      = 8'h00;
               next_state    = S_STRB;
            end else if (resp_late) begin
               // no strobe without a select response; tag is dropped
               next_timeout  = 1'b1;
               next_active_n = 1'b1;
               next_state    = S_DROP;
            end else begin
               next_cnt = cnt + 8'h01;
            end
         end
         S_STRB: begin
            if (strobe_end) begin
               next_strobe_n = 1'b1;
               next_state    = S_DROP;
            end else begin
               next_cnt = cnt + 8'h01;
            end
         end
         S_DROP: begin
            next_active_n = 1'b1;
            next_state    = S_ADDR;
         end
         S_ADDR: begin
            // address released last, bounded overhead
            next_addr_n     = {ADDR_W{1'b1}};
            next_addr_oe    = 1'b0;
            next_dbus_n     = 8'hff;
            next_dbus_par_n = 1'b1;
            next_busy       = 1'b0;
            next_done       = 1'b1;
            next_state      = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // sequencer state and phase counter
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= S_IDLE;
         cnt   <= 8'h00;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // exchange status towards the processor side
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         SVC_BUSY    <= 1'b0;
         SVC_DONE    <= 1'b0;
         SVC_TIMEOUT <= 1'b0;
      end else begin
         SVC_BUSY    <= next_busy;
         SVC_DONE    <= next_done;
         SVC_TIMEOUT <= next_timeout;
      end
   end

   // captured response, held until the next capture
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         SVC_DATA    <= `DATA_RESET;
         SVC_COND    <= 4'h0;
         SVC_PAR_ERR <= 1'b0;
      end else begin
         SVC_DATA    <= next_data;
         SVC_COND    <= next_cond;
         SVC_PAR_ERR <= next_par_err;
      end
   end

   // address lines, idle high
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ADDR_N  <= {ADDR_W{1'b1}};
         ADDR_OE <= 1'b0;
      end else begin
         ADDR_N  <= next_addr_n;
         ADDR_OE <= next_addr_oe;
      end
   end

   // service-active tag and strobe, idle high
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         SVC_ACTIVE_N <= 1'b1;
         STROBE_N     <= 1'b1;
      end else begin
         SVC_ACTIVE_N <= next_active_n;
         STROBE_N     <= next_strobe_n;
      end
   end

   // outbound byte and its parity line, idle high
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         DBUS_OUT_N     <= 8'hff;
         DBUS_OUT_PAR_N <= 1'b1;
      end else begin
         DBUS_OUT_N     <= next_dbus_n;
         DBUS_OUT_PAR_N <= next_dbus_par_n;
      end
   end
endmodule
`default_nettype wire

/* rtl/isvc_defines.vh */
// timing constants and reset values for the interrupt service handshake
`ifndef ISVC_DEFINES_VH
`define ISVC_DEFINES_VH
`define CLK_PERIOD_NS      100
`define ADDR_SKEW_NS       200
`define ADDR_SKEW_CYC      ((`ADDR_SKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_WIDTH_NS    200
`define STROBE_WIDTH_CYC   ((`STROBE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVERHEAD_MAX_NS    2500
`define OVERHEAD_MAX_CYC   (`OVERHEAD_MAX_NS / `CLK_PERIOD_NS)
`define RESP_TIMEOUT_CYC   255
`define ADDR_RESET         8'h00
`define DATA_RESET         8'h00
`endif

/* rtl/tag_sync.v */
// two-flop synchroniser for a group of tag inputs
`timescale 1ns/1ns
`default_nettype none
module tag_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] meta;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

/* tb/isvc_handshake_properties.sv */
// tag ordering checks on the service handshake pins
`timescale 1ns/1ns
`default_nettype none
module isvc_handshake_checker (
   input wire logic       CLK,
   input wire logic       SYS_RST,
   input wire logic       SVC_START,
   input wire logic       SVC_BUSY,
   input wire logic       ADDR_OE,
   input wire logic [7:0] ADDR_N,
   input wire logic       SVC_ACTIVE_N,
   input wire logic       STROBE_N,
   input wire logic       SEL_RESP_N
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_pulse;
      !STROBE_N ##1 STROBE_N;
   endsequence
   a_start_drive: assert property (SVC_START && !SVC_BUSY |=> SVC_BUSY && ADDR_OE)
      else $error("address not driven");
   a_tag_skew: assert property ($fell(SVC_ACTIVE_N) |-> $past(ADDR_OE, 2))
      else $error("tag too early");
   a_strobe_pulse: assert property ($fell(STROBE_N) |=> s_pulse)
      else $error("strobe width");
   a_strobe_in_tag: assert property (!STROBE_N |-> !SVC_ACTIVE_N)
      else $error("strobe outside tag");
   a_strobe_cause: assert property ($fell(STROBE_N) |-> !$past(SEL_RESP_N, 2))
      else $error("strobe without select");
   a_tag_release: assert property ($rose(SVC_ACTIVE_N) |-> STROBE_N && $past(STROBE_N))
      else $error("tag dropped in strobe");
   a_addr_last: assert property ($fell(ADDR_OE) |-> SVC_ACTIVE_N && $past(SVC_ACTIVE_N))
      else $error("address dropped early");
   a_idle_level: assert property (!SVC_BUSY |-> SVC_ACTIVE_N && STROBE_N && (ADDR_OE || ADDR_N == 8'hff))
      else $error("idle lines not high");
endmodule
bind isvc_handshake isvc_handshake_checker u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .SVC_START(SVC_START),
   .SVC_BUSY(SVC_BUSY), .ADDR_OE(ADDR_OE), .ADDR_N(ADDR_N), .SVC_ACTIVE_N(SVC_ACTIVE_N),
   .STROBE_N(STROBE_N), .SEL_RESP_N(SEL_RESP_N));
`default_nettype wire

/* tb/svc_device.sv */
// behavioural attached device answering the service exchange
`timescale 1ns/1ns
`default_nettype none
module svc_device #(
   parameter logic [7:0] ADDR = 8'h5a
) (
   input  wire logic        clk,
   input  wire logic [7:0]  addr_n,
   input  wire logic        active_n,
   input  wire logic        strobe_n,
   input  wire logic [3:0]  dly,
   input  wire logic [12:0] resp,
   input  wire logic [15:0] irq_set,
   output logic             sel_n,
   output logic [12:0]      bus_n,
   output logic [15:0]      irq_n
);
   logic [3:0]  cnt = 4'h0;
   logic [15:0] irq = 16'h0;
   logic        st_q = 1'b1;
   // released lines float to the terminator level
   assign bus_n = sel_n ? 13'h1fff : ~resp;
   assign irq_n = ~irq;
   initial sel_n = 1'b1;
   always @(posedge clk) begin
      st_q <= strobe_n;
      if (st_q && !strobe_n) irq <= 16'h0;
      else irq <= irq | irq_set;
      if (active_n) begin
         cnt <= 4'h0;
         sel_n <= 1'b1;
      end else if (~addr_n == ADDR) begin
         if (cnt == dly) sel_n <= 1'b0;
         else cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* tb/tb_program_io_interrupt_service_handshake.sv */
// self-checking bench for the interrupt service handshake
`timescale 1ns/1ns
`default_nettype none
module tb_program_io_interrupt_service_handshake;
   logic        CLK = 0, SYS_RST = 1, start = 0, busy, done, tmo, perr, sel_n, act_n, stb_n, oe, dpar_n, tflag = 0;
   logic [7:0]  adr = 0, dout = 0, data, addr_n, dbo_n;
   logic [12:0] resp = 0, bus_n, last = 0;
   logic [3:0]  dly = 0, cond;
   logic [15:0] irq_set = 0, irq_n, pend;
   logic [13:0] exq[$];
   int          fails = 0, n_tests = 0, cyc = 0, n;
   isvc_handshake u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .SVC_START(start), .SVC_ADDR(adr), .DATA_OUT_VAL(dout),
      .SVC_BUSY(busy), .SVC_DONE(done), .SVC_TIMEOUT(tmo), .SVC_DATA(data), .SVC_COND(cond), .SVC_PAR_ERR(perr),
      .IRQ_PENDING(pend), .ADDR_N(addr_n), .ADDR_OE(oe), .SVC_ACTIVE_N(act_n), .STROBE_N(stb_n),
      .DBUS_OUT_N(dbo_n), .DBUS_OUT_PAR_N(dpar_n), .SEL_RESP_N(sel_n), .COND_IN_N(bus_n[11:8]),
      .DBUS_IN_N(bus_n[7:0]), .DBUS_IN_PAR_N(bus_n[12]), .IRQ_N(irq_n));
   svc_device u_dev (.clk(CLK), .addr_n(addr_n), .active_n(act_n), .strobe_n(stb_n), .dly(dly), .resp(resp),
      .irq_set(irq_set), .sel_n(sel_n), .bus_n(bus_n), .irq_n(irq_n));
   initial begin
      forever #50 CLK = ~CLK;
   end
   task automatic cmp_res(input logic [13:0] got, input logic [13:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %0t result %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_irq(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one exchange; a foreign address must end in a timeout
   task automatic run(input logic [7:0] a, input logic [3:0] d);
      logic [12:0] r, e;
      r = {1'b0, 12'($urandom)};
      r[12] = ~^r[7:0] ^ ($urandom_range(3) == 0);
      e = {r[12] ^ ~^r[7:0], r[11:0]};
      @(negedge CLK);
      {adr, dly, resp, dout, start} = {a, d, r, 8'($urandom), 1'b1};
      // a timeout is followed by done and leaves the last capture in place
      exq.push_back(a == 8'h5a ? {1'b0, e} : {1'b1, last});
      if (a == 8'h5a) last = e;
      @(negedge CLK);
      start = 0;
      cmp_irq({7'h0, dpar_n, dbo_n}, {7'h0, ^dout, ~dout});
      cmp_irq({7'h0, oe, addr_n}, {7'h0, 1'b1, ~a});
      n = 1;
      while (busy === 1'b1 && n < 400) begin
         @(negedge CLK);
         n++;
      end
      cmp_irq({7'h0, oe, addr_n}, 16'h00ff);
      if (d == 0 && a == 8'h5a) cmp_irq(16'(n > 25), 16'h0);
   endtask
   always @(posedge CLK) begin
      if (tmo === 1'b1) tflag = 1'b1;
      if (done === 1'b1) begin
         cmp_res({tflag, perr, cond, data}, exq.pop_front());
         tflag = 1'b0;
      end
   end
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         report_and_stop;
      end
   end
   initial begin
      void'($urandom(32'h2bca1599));
      repeat (20) @(negedge CLK);
      SYS_RST = 0;
      irq_set = 16'($urandom) | 16'h8001;
      repeat (6) @(negedge CLK);
      cmp_irq(pend, irq_set);
      irq_set = 0;
      for (int i = 0; i < 12; i++) run(i == 5 ? 8'h33 : 8'h5a, 4'(i % 6));
      repeat (6) @(negedge CLK);
      cmp_irq(pend, 16'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
